// ===== hpp_pkg.sv
// package for the host parallel bus port: constants, field layout and types
package hpp_pkg;
  // timing
  localparam int CLK_NS = 8;
  localparam int LATE_ADDR_NS = 50;
  localparam int LATE_ADDR_CYC = (LATE_ADDR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] LATE_CNT = 4'(LATE_ADDR_CYC);
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // word indexes of the host-visible registers
  localparam logic [4:0] STATUS_WORD = 5'h00;
  localparam logic [4:0] CFG_WORD = 5'h01;
  localparam logic [4:0] MODE_WORD = 5'h02;
  // configuration word fields and the mode word source bit
  localparam int CFG_PS_LSB = 0;
  localparam int CFG_NID_LSB = 2;
  localparam int CFG_MAX_LSB = 7;
  localparam int CFG_RATE_LSB = 12;
  localparam int CFG_ET_BIT = 15;
  localparam int MODE_SRC_BIT = 0;
  // reset values
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic IRQ_IDLE = 1'b1;

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DRIVE} hpp_rd_t;

  typedef struct packed {
    logic cs_n;
    logic wsd;
    logic rsd;
    logic [5:0] addr;
    logic [15:0] data;
    logic style;
    logic sep_addr;
    logic w16;
    logic swap;
    logic ds_pol;
    logic wr_timing;
    logic rd_timing;
    logic [1:0] ps;
    logic [4:0] nid;
    logic [4:0] maxid;
    logic [2:0] rate;
    logic et;
  } hpp_pins_t;

  typedef struct packed {
    logic style;
    logic sep_addr;
    logic w16;
    logic swap;
    logic ds_pol;
    logic wr_timing;
    logic rd_timing;
  } hpp_straps_t;

  typedef struct packed {
    hpp_pins_t s1;
    hpp_pins_t s2;
    logic ale_prev;
    hpp_straps_t st;
    logic [1:0] strap_cnt;
    logic strap_ok;
    logic [5:0] mux_addr;
    logic wr_prev;
    logic [5:0] wr_addr;
    logic [15:0] wr_data;
    hpp_rd_t rd;
    logic [3:0] rd_cnt;
    logic [5:0] rd_addr;
    logic [15:0] dout;
    logic doe;
    logic irq_n;
    logic [1:0] ps;
    logic [4:0] nid;
    logic [4:0] maxid;
    logic [2:0] rate;
    logic et;
    logic [31:0][15:0] regs;
  } hpp_state_t;
endpackage : hpp_pkg

// ===== hpp_port.sv
// host parallel bus port: strobes, address capture, register file, config select
// Operation
// RULE1 - strobe-style strap picks separate read/write strobes or data strobe plus direction
// RULE2 - write is data strobe with direction low, or the write strobe
// RULE3 - read is data strobe with direction high, or the read strobe
// RULE4 - data strobe active low when polarity strap high, else active high
// RULE5 - multiplex strap picks address on low data lines or separate address inputs
// RULE6 - six-bit register address; multiplexed on data lines 5..0
// RULE7 - multiplexed: address 2 is latch strobe, address 3 its polarity
// RULE8 - latch polarity high captures on falling edge, low on rising edge
// RULE9 - write timing strap high: write ends when select or strobe drops
// RULE10 - write timing strap low: write ends when the strobe is released
// RULE11 - read timing strap high: address taken at read start
// RULE12 - read timing strap low: address taken later in the read
// RULE13 - late read capture delayed about 50 ns
// RULE14 - bus width strap high gives 16-bit bus, low gives 8-bit
// RULE15 - 16-bit mode forces address bit 0 to zero
// RULE16 - registers 16 bits, byte lane chosen by address bit 0 in 8-bit mode
// RULE17 - byte order strap low: low byte even, high byte odd
// RULE18 - byte order strap high: low byte odd, high byte even
// RULE19 - interrupt requests drive the interrupt output low
// RULE20 - reset input low holds the device in reset
// RULE21 - network settings come from straps or from host registers
// RULE22 - strobes ignored without chip select; data driven only during reads
// RULE23 - host interface straps sampled at reset, then held constant
`timescale 1ns/1ps
module hpp_port
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // host bus pins
  input wire logic chip_select_low,
  input wire logic write_strobe_or_direction,
  input wire logic read_strobe_or_data_strobe,
  input wire logic [5:0] addr_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic interrupt_request_low,
  // interface straps
  input wire logic strobe_style_strap,
  input wire logic address_multiplex_strap,
  input wire logic bus_width_strap,
  input wire logic byte_order_strap,
  input wire logic strobe_polarity_strap,
  input wire logic write_timing_strap,
  input wire logic read_timing_strap,
  // network setting straps
  input wire logic [1:0] page_size_setting,
  input wire logic [4:0] own_node_number,
  input wire logic [4:0] max_node_number,
  input wire logic [2:0] data_rate_setting,
  input wire logic extended_timer_setting,
  // core side, same clock
  input wire logic core_irq,
  input wire logic [15:0] core_status,
  output logic [1:0] page_size_out,
  output logic [4:0] own_node_out,
  output logic [4:0] max_node_out,
  output logic [2:0] data_rate_out,
  output logic ext_timer_out
);

  // byte lane of an 8-bit access
  function automatic logic lane_hi(input logic a0, input logic swap);
    lane_hi = a0 ^ swap; // RULE17 RULE18
  endfunction : lane_hi

  // address as seen inside, bit 0 dropped on a 16-bit bus
  function automatic logic [5:0] fix_addr(input logic [5:0] a, input logic w16);
    fix_addr = w16 ? {a[5:1], 1'b0} : a; // RULE15
  endfunction : fix_addr

  logic [1:0] rst_ff;
  logic rst_q;
  hpp_state_t s;
  hpp_state_t next_s;
  hpp_pins_t p;
  logic ds_on;
  logic wr_on;
  logic rd_on;
  logic wr_act;
  logic rd_act;
  logic wr_track;
  logic wr_commit;
  logic ale_cap;
  logic rd_cap;
  logic [5:0] cur_addr;
  logic [15:0] rd_word;
  logic cfg_src;

  // read data for a read address, built from the frozen straps
  function automatic logic [15:0] read_data(input logic [5:0] a);
    logic [15:0] w;
    w = (a[5:1] == STATUS_WORD) ? core_status : s.regs[a[5:1]];
    if (s.st.w16) begin
      read_data = w; // RULE14
    end else if (lane_hi(a[0], s.st.swap)) begin
      read_data = {8'h00, w[15:8]}; // RULE16
    end else begin
      read_data = {8'h00, w[7:0]};
    end
  endfunction : read_data

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b) begin // RULE20
    if (!rst_b) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_q = rst_ff[1];

  // decode of the synchronised pins
  always_comb begin
    p = s.s2;
    ds_on = s.st.ds_pol ? ~p.rsd : p.rsd; // RULE4
    wr_on = s.st.style ? (ds_on & ~p.wsd) : ~p.wsd; // RULE1 RULE2
    rd_on = s.st.style ? (ds_on & p.wsd) : ~p.rsd; // RULE1 RULE3
    wr_act = ~p.cs_n & wr_on & s.strap_ok; // RULE22
    rd_act = ~p.cs_n & rd_on & s.strap_ok; // RULE22
    // early-release hosts: the access ends with select or strobe
    wr_track = s.st.wr_timing ? wr_act // RULE9
             : (wr_on & s.strap_ok & (~p.cs_n | s.wr_prev)); // RULE10
    wr_commit = s.wr_prev & ~wr_track;
    ale_cap = p.addr[3] ? (s.ale_prev & ~p.addr[2]) // RULE7 RULE8
            : (~s.ale_prev & p.addr[2]);
    cur_addr = fix_addr(s.st.sep_addr ? p.addr : s.mux_addr, s.st.w16); // RULE5 RULE6
    rd_cap = 1'b0;
    if (s.rd == RD_IDLE) begin
      rd_cap = rd_act & s.st.rd_timing; // RULE11
    end else if (s.rd == RD_WAIT) begin
      rd_cap = rd_act & (s.rd_cnt == LATE_CNT); // RULE12 RULE13
    end
    cfg_src = s.regs[MODE_WORD][MODE_SRC_BIT];
  end

  // next state of the whole port
  always_comb begin
    next_s = s;
    next_s.s1 = {chip_select_low, write_strobe_or_direction, read_strobe_or_data_strobe,
                 addr_in, data_in, strobe_style_strap, address_multiplex_strap,
                 bus_width_strap, byte_order_strap, strobe_polarity_strap,
                 write_timing_strap, read_timing_strap, page_size_setting,
                 own_node_number, max_node_number, data_rate_setting,
                 extended_timer_setting};
    next_s.s2 = s.s1;
    next_s.ale_prev = s.s2.addr[2];
    // straps follow the pins only until the pipeline has filled after reset
    if (!s.strap_ok) begin // RULE23
      next_s.st = {p.style, p.sep_addr, p.w16, p.swap, p.ds_pol, p.wr_timing, p.rd_timing};
      next_s.strap_cnt = s.strap_cnt + 2'h1;
      next_s.strap_ok = (s.strap_cnt == STRAP_WAIT);
    end
    if (!s.st.sep_addr && ale_cap) begin
      next_s.mux_addr = p.data[5:0]; // RULE6 RULE8
    end
    // write path: address and data follow the bus while selected
    next_s.wr_prev = wr_track;
    if (wr_act) begin
      next_s.wr_addr = cur_addr;
      next_s.wr_data = p.data;
    end
    if (wr_commit) begin
      if (s.st.w16) begin
        next_s.regs[s.wr_addr[5:1]] = s.wr_data; // RULE14 RULE16
      end else if (lane_hi(s.wr_addr[0], s.st.swap)) begin
        next_s.regs[s.wr_addr[5:1]][15:8] = s.wr_data[7:0]; // RULE18
      end else begin
        next_s.regs[s.wr_addr[5:1]][7:0] = s.wr_data[7:0]; // RULE17
      end
    end
    // read sequencer
    unique case (s.rd)
      RD_IDLE: begin
        if (rd_act) begin
          next_s.rd = s.st.rd_timing ? RD_DRIVE : RD_WAIT;
          next_s.rd_cnt = 4'h1;
        end
      end
      RD_WAIT: begin
        if (!rd_act) begin
          next_s.rd = RD_IDLE;
        end else if (rd_cap) begin
          next_s.rd = RD_DRIVE;
        end else begin
          next_s.rd_cnt = s.rd_cnt + 4'h1;
        end
      end
      RD_DRIVE: begin
        if (!rd_act) begin
          next_s.rd = RD_IDLE;
        end
      end
      // an unused code falls back to idle
      default: begin
        next_s.rd = RD_IDLE;
      end
    endcase
    if (rd_cap) begin
      next_s.rd_addr = cur_addr;
    end
    // data refreshed each cycle so a status or register change is seen
    next_s.doe = (next_s.rd == RD_DRIVE); // RULE22
    rd_word = read_data(next_s.rd_addr);
    next_s.dout = next_s.doe ? rd_word : DATA_RST;
    next_s.irq_n = ~core_irq; // RULE19
    // network settings from straps or from the host
    if (cfg_src) begin // RULE21
      next_s.ps = s.regs[CFG_WORD][CFG_PS_LSB +: 2];
      next_s.nid = s.regs[CFG_WORD][CFG_NID_LSB +: 5];
      next_s.maxid = s.regs[CFG_WORD][CFG_MAX_LSB +: 5];
      next_s.rate = s.regs[CFG_WORD][CFG_RATE_LSB +: 3];
      next_s.et = s.regs[CFG_WORD][CFG_ET_BIT];
    end else begin
      next_s.ps = p.ps;
      next_s.nid = p.nid;
      next_s.maxid = p.maxid;
      next_s.rate = p.rate;
      next_s.et = p.et;
    end
  end

  // state register; synchronised select idles high after reset so nothing looks selected
  always_ff @(posedge sys_clk or negedge rst_q) begin // RULE20
    if (!rst_q) begin
      s <= '0;
      s.s1.cs_n <= 1'b1;
      s.s2.cs_n <= 1'b1;
      s.irq_n <= IRQ_IDLE;
      s.regs <= {32{REG_RST}};
      s.rd <= RD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign data_out = s.dout;
  assign data_oe = s.doe;
  assign interrupt_request_low = s.irq_n;
  assign page_size_out = s.ps;
  assign own_node_out = s.nid;
  assign max_node_out = s.maxid;
  assign data_rate_out = s.rate;
  assign ext_timer_out = s.et;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_q);

  sequence late_start_s;
    s.rd == RD_IDLE && rd_act && !s.st.rd_timing;
  endsequence

  sequence late_hold_s;
    rd_act [*7];
  endsequence

  read_drive_a: assert property (data_oe |-> $past(rd_act)) // RULE22
    else $error("data driven without a selected read");
  idle_release_a: assert property (!rd_act |=> !data_oe) // RULE22
    else $error("data still driven after read ended");
  late_addr_a: assert property (late_start_s ##1 late_hold_s |-> rd_cap) // RULE13
    else $error("late read address not taken after seven cycles");
  early_addr_a: assert property ( // RULE11
    s.rd == RD_IDLE && rd_act && s.st.rd_timing |-> rd_cap ##1 data_oe)
    else $error("early read address not taken at start");
  latch_fall_a: assert property ( // RULE8
    !s.st.sep_addr && s.s2.addr[3] && s.ale_prev && !s.s2.addr[2]
    |=> s.mux_addr == $past(s.s2.data[5:0]))
    else $error("muxed address missed on latch falling edge");
  strap_hold_a: assert property (s.strap_ok |=> $stable(s.st)) // RULE23
    else $error("straps changed in operation");
  lsb_zero_a: assert property (wr_act && s.st.w16 |=> !s.wr_addr[0]) // RULE15
    else $error("address bit 0 not forced in 16-bit mode");
  word_write_a: assert property ( // RULE14
    wr_commit && s.st.w16 |=> s.regs[$past(s.wr_addr[5:1])] == $past(s.wr_data))
    else $error("16-bit write not stored");
  even_low_a: assert property ( // RULE17
    wr_commit && !s.st.w16 && !s.st.swap && !s.wr_addr[0]
    |=> s.regs[$past(s.wr_addr[5:1])][7:0] == $past(s.wr_data[7:0]))
    else $error("even byte not in low lane");
  odd_low_a: assert property ( // RULE18
    wr_commit && !s.st.w16 && s.st.swap && s.wr_addr[0]
    |=> s.regs[$past(s.wr_addr[5:1])][7:0] == $past(s.wr_data[7:0]))
    else $error("swapped odd byte not in low lane");
  cs_first_a: assert property ( // RULE9
    s.st.wr_timing && s.wr_prev && p.cs_n && wr_on |-> wr_commit)
    else $error("early select release did not end write");
  strobe_end_a: assert property ( // RULE10
    !s.st.wr_timing && s.wr_prev && p.cs_n && wr_on |-> !wr_commit)
    else $error("write ended before strobe release");
  irq_low_a: assert property (core_irq |=> !interrupt_request_low) // RULE19
    else $error("interrupt request not driven low");
  cfg_reg_a: assert property ( // RULE21
    cfg_src |=> own_node_out == $past(s.regs[CFG_WORD][CFG_NID_LSB +: 5]))
    else $error("node number not taken from register");

  // strobe decode and address path
  sequence ds_strobe_s;
    s.strap_ok && !p.cs_n && s.st.style && ds_on;
  endsequence

  sequence idle_start_s;
    s.rd == RD_IDLE && s.strap_ok && !p.cs_n;
  endsequence

  ds_write_a: assert property (ds_strobe_s ##0 !p.wsd |=> s.wr_prev) // RULE2
    else $error("data strobe with direction low not taken as write");
  ds_read_a: assert property ( // RULE3
    idle_start_s ##0 (s.st.style && ds_on && p.wsd) |=> s.rd != RD_IDLE)
    else $error("data strobe with direction high not taken as read");
  rd_strobe_a: assert property ( // RULE3
    idle_start_s ##0 (!s.st.style && !p.rsd) |=> s.rd != RD_IDLE)
    else $error("read strobe not taken as read");
  ds_level_a: assert property ( // RULE4
    s.st.style && p.rsd == s.st.ds_pol |-> !wr_act && !rd_act)
    else $error("data strobe taken at its inactive level");
  pin_addr_a: assert property ( // RULE5
    s.st.sep_addr && !s.st.w16 && rd_cap |=> s.rd_addr == $past(p.addr))
    else $error("separate address pins not used");
  mux_addr_a: assert property ( // RULE6
    !s.st.sep_addr && !s.st.w16 && rd_cap |=> s.rd_addr == $past(s.mux_addr))
    else $error("latched address not used for read");
  latch_rise_a: assert property ( // RULE7
    !s.st.sep_addr && !s.s2.addr[3] && !s.ale_prev && s.s2.addr[2]
    |=> s.mux_addr == $past(s.s2.data[5:0]))
    else $error("muxed address missed on latch rising edge");
  late_first_a: assert property (late_start_s |-> !rd_cap ##1 !data_oe) // RULE12
    else $error("late read address taken at read start");
  wait_count_a: assert property (s.rd == RD_WAIT |-> s.rd_cnt <= LATE_CNT) // RULE13
    else $error("late read wait ran past its count");
  byte_read_a: assert property (data_oe && !s.st.w16 |-> data_out[15:8] == 8'h00) // RULE16
    else $error("8-bit read drives upper data lines");
  irq_clear_a: assert property (!core_irq |=> interrupt_request_low) // RULE19
    else $error("interrupt request held low without a request");
  pin_cfg_a: assert property (!cfg_src |=> own_node_out == $past(p.nid)) // RULE21
    else $error("node number not taken from pins");
  no_select_a: assert property (p.cs_n && !s.wr_prev |=> !s.wr_prev) // RULE22
    else $error("write started without chip select");

endmodule : hpp_port

// ===== hpp_host.sv
// host cpu model that drives the port's bus pins
`timescale 1ns/1ps
module hpp_host (
  // clock and port answer
  input wire logic sys_clk,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  // straps as the host was built for them
  input wire logic [6:0] st,
  // host bus pins
  output logic chip_select_low,
  output logic write_strobe_or_direction,
  output logic read_strobe_or_data_strobe,
  output logic [5:0] addr_in,
  output logic [15:0] data_in
);
  logic [15:0] hd;
  // port drives while enabled; a released host shows the inverse of its last value
  assign data_in = data_oe ? data_out : hd;
  initial begin
    hd = 16'h0000;
    chip_select_low = 1'b1;
    write_strobe_or_direction = 1'b1;
    read_strobe_or_data_strobe = 1'b1;
    addr_in = 6'h00;
  end
  // inactive strobe levels for the style in use
  task automatic rel;
    write_strobe_or_direction = 1'b1;
    read_strobe_or_data_strobe = st[6] ? st[2] : 1'b1;
  endtask : rel
  // one access, rw high reads; q and oe are the port answer
  task automatic acc(input logic rw, input logic sel, input logic [5:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic oe);
    rel();
    if (!st[5]) begin
      addr_in = {2'h0, st[3], st[3], 2'h0};
      hd = {10'h000, a};
      repeat (3) @(negedge sys_clk);
      addr_in[2] = ~st[3];
      repeat (3) @(negedge sys_clk);
      addr_in[2] = st[3];
    end else begin
      addr_in = (rw && !st[0]) ? ~a : a;
    end
    hd = rw ? ~hd : d;
    chip_select_low = ~sel;
    if (st[6]) begin
      write_strobe_or_direction = rw;
      read_strobe_or_data_strobe = ~st[2];
    end else if (rw) read_strobe_or_data_strobe = 1'b0;
    else write_strobe_or_direction = 1'b0;
    repeat (2) @(negedge sys_clk);
    if (st[5]) addr_in = a;
    repeat (6) @(negedge sys_clk);
    // bounded wait for the port to take the bus
    for (int k = 0; k < 20 && rw && data_oe !== 1'b1; k++) @(negedge sys_clk);
    q = data_out;
    oe = data_oe;
    // write timing strap high: every access drops select first; low: odd-address writes do, so the strobe-tracking path is used
    if (st[1] || (!rw && a[0])) chip_select_low = 1'b1;
    else rel();
    @(negedge sys_clk);
    chip_select_low = 1'b1;
    rel();
    hd = ~hd;
    repeat (5) @(negedge sys_clk);
  endtask : acc
endmodule : hpp_host

// ===== tb.sv
// self-checking bench for the host parallel bus port
`timescale 1ns/1ps
module tb;
  import hpp_pkg::*;
  logic sys_clk, rst_b, core_irq, irq_n, doe, cs_n, wsd, rsd, et;
  logic [15:0] core_status, dout, din, net, w, r;
  logic [6:0] st, sp;
  logic [5:0] addr;
  logic [1:0] ps;
  logic [4:0] nid, mx;
  logic [2:0] rate;
  int err_total, samples_checked;
  hpp_port hpp_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .chip_select_low(cs_n),
    .write_strobe_or_direction(wsd), .read_strobe_or_data_strobe(rsd), .addr_in(addr),
    .data_in(din), .data_out(dout), .data_oe(doe), .interrupt_request_low(irq_n),
    .strobe_style_strap(sp[6]), .address_multiplex_strap(sp[5]), .bus_width_strap(sp[4]),
    .byte_order_strap(sp[3]), .strobe_polarity_strap(sp[2]), .write_timing_strap(sp[1]),
    .read_timing_strap(sp[0]), .page_size_setting(net[1:0]), .own_node_number(net[6:2]),
    .max_node_number(net[11:7]), .data_rate_setting(net[14:12]),
    .extended_timer_setting(net[15]), .core_irq(core_irq), .core_status(core_status),
    .page_size_out(ps), .own_node_out(nid), .max_node_out(mx), .data_rate_out(rate),
    .ext_timer_out(et));
  hpp_host hpp_host_inst (.sys_clk(sys_clk), .data_out(dout), .data_oe(doe), .st(st),
    .chip_select_low(cs_n), .write_strobe_or_direction(wsd),
    .read_strobe_or_data_strobe(rsd), .addr_in(addr), .data_in(din));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // word write; in 8-bit mode the lane is high when lsb xor byte order
  task automatic wr_word(input logic sel, input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic oe;
    if (st[4]) hpp_host_inst.acc(1'b0, sel, {a, 1'($urandom)}, d, q, oe);
    else for (int i = 0; i < 2; i++) begin
      hpp_host_inst.acc(1'b0, sel, {a, i[0]}, (i[0] ^ st[3]) ? d >> 8 : d & 16'h00ff, q, oe);
    end
  endtask : wr_word
  // word read; a missing bus answer ends the run
  task automatic rd_word(input logic [4:0] a, output logic [15:0] v);
    logic [15:0] q;
    logic oe;
    for (int i = 0; i < (st[4] ? 1 : 2); i++) begin
      hpp_host_inst.acc(1'b1, 1'b1, {a, st[4] ? 1'($urandom) : i[0]}, 16'h0000, q, oe);
      cmp("read answer", 16'h0001, {15'h0000, oe});
      if (oe !== 1'b1) end_of_test();
      if (st[4]) v = q;
      else if (i[0] ^ st[3]) v[15:8] = q[7:0];
      else v[7:0] = q[7:0];
    end
  endtask : rd_word
  // one strap set per pass: reset, write, refused write, reads, settings, interrupt
  initial begin
    void'($urandom(32'h5d7e));
    {rst_b, core_irq, core_status, net, st, sp, err_total, samples_checked} = '0;
    for (int c = 0; c < 8; c++) begin
      @(negedge sys_clk);
      rst_b = 1'b0;
      st = {c[0], c[1], c[2], c[0] ^ c[1], c[1] ^ c[2], c[0] ^ c[2], ^c[2:0]};
      sp = st;
      net = 16'($urandom);
      core_status = 16'($urandom);
      w = (c == 0) ? 16'hffff : 16'($urandom);
      repeat (16) @(negedge sys_clk);
      cmp("reset settings", 16'h0000, {et, rate, mx, nid, ps});
      cmp("reset bus", {14'h0000, 1'b0, IRQ_IDLE}, {14'h0000, doe, irq_n});
      cmp("reset data", DATA_RST, dout);
      rst_b = 1'b1;
      repeat (12) @(negedge sys_clk);
      wr_word(1'b1, CFG_WORD, w);
      rd_word(CFG_WORD, r);
      cmp("cfg word", w, r);
      wr_word(1'b0, CFG_WORD, ~w);
      rd_word(CFG_WORD, r);
      cmp("unselected write", w, r);
      sp = ~st;
      rd_word(STATUS_WORD, r);
      cmp("status word", core_status, r);
      if (c[0]) wr_word(1'b1, MODE_WORD, 16'h0001);
      repeat (3) @(negedge sys_clk);
      cmp("settings", c[0] ? w : net, {et, rate, mx, nid, ps});
      core_irq = 1'b1;
      repeat (2) @(negedge sys_clk);
      cmp("irq on", 16'h0000, {15'h0000, irq_n});
      core_irq = 1'b0;
      repeat (2) @(negedge sys_clk);
      cmp("irq off", 16'h0001, {15'h0000, irq_n});
    end
    end_of_test();
  end
endmodule : tb
